// file: core_model.sv
// Core side model: issues one table read and waits out the stall.
// Assumes the table-read unit shares clk_sys_i.
`timescale 1ns/1ps
module core_model (
	input wire logic clk_sys_i,
	input wire logic stall_i,
	output table_read_pkg::table_cmd_s cmd_o
);
	initial cmd_o = '0;
	// region select is software's; this core only reads program flash
	task automatic issue(input table_read_pkg::ptr_mode_e mode, output int n);
		n = 0;
		@(posedge clk_sys_i);
		#1 cmd_o = {1'b1, mode};
		@(posedge clk_sys_i);
		#1 cmd_o = '0;
		// Bounded so a stuck stall cannot hang the core
		while (stall_i === 1'b1 && n < 4) begin
			n++;
			@(posedge clk_sys_i);
			#1;
		end
	endtask : issue
endmodule : core_model

// file: prog_word_mem.sv
// Word-organised program memory array with a registered read port.
// Assumes the fill port and the read port are driven from the same clock.
`timescale 1ns/1ps
module prog_word_mem (
	input wire logic clk_sys_i,
	input wire logic rd_en_i,
	input wire logic [table_read_pkg::WORD_ADDR_W-1:0] rd_addr_i,
	output logic [table_read_pkg::WORD_W-1:0] rd_data_o,
	input table_read_pkg::prog_write_s wr_i
);
	logic [table_read_pkg::WORD_W-1:0] mem [table_read_pkg::MEM_DEPTH];

	// No reset on the array so it can map onto block memory
	always_ff @(posedge clk_sys_i) begin
		if (wr_i.we) begin
			mem[wr_i.addr] <= wr_i.data;
		end
		if (rd_en_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule : prog_word_mem

// file: table_read_pkg.sv
// Constants, modes and carriers for the program memory table-read path.
// Assumes a core that issues one table-read request at a time and honours stall.
// What this block does
// - Every table read moves exactly one byte; wider values need several reads.
// - The table pointer holds a byte address, not a word address.
// - A table read loads the byte the pointer selects into the latch.
// - A table read may update the pointer to address the next byte.
// - The core is stalled during the read and released as soon as it completes.
// - The latch holds the byte for the instruction in the following cycle.
// - Memory is word organised; pointer bit zero picks high or low byte.
// - Post-increment read returns the addressed byte, then advances the pointer by one.
package table_read_pkg;
	localparam int PTR_W = 17;
	localparam int WORD_ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int MEM_DEPTH = 65536;
	localparam int SEL_BIT = 0;
	localparam int HIGH_BYTE_LSB = 8;
	localparam logic [PTR_W-1:0] PTR_RESET = 17'h00000;
	localparam logic [PTR_W-1:0] PTR_STEP = 17'h00001;
	localparam logic [BYTE_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

	typedef enum logic [1:0] {
		MODE_HOLD = 2'h0,
		MODE_POST_INC = 2'h1,
		MODE_POST_DEC = 2'h2,
		MODE_PRE_INC = 2'h3
	} ptr_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_READ = 2'h2
	} rd_state_e;

	typedef struct packed {
		logic valid;
		ptr_mode_e mode;
	} table_cmd_s;

	typedef struct packed {
		logic we;
		logic [WORD_ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} prog_write_s;
endpackage : table_read_pkg

// file: table_read_unit.sv
// Table-read engine: byte pointer, word fetch, byte select, latch and core stall.
// Assumes the core raises a one-cycle request and freezes while stall is high.
`timescale 1ns/1ps
module table_read_unit (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input table_read_pkg::table_cmd_s cmd_i,
	input wire logic ptr_load_i,
	input wire logic [table_read_pkg::PTR_W-1:0] ptr_data_i,
	input table_read_pkg::prog_write_s prog_wr_i,
	output logic [table_read_pkg::PTR_W-1:0] table_byte_pointer_o,
	output logic [table_read_pkg::BYTE_W-1:0] table_read_latch_o,
	output logic stall_o,
	output logic latch_valid_o
);
	table_read_pkg::rd_state_e state_reg, state_next;
	logic [table_read_pkg::PTR_W-1:0] ptr_reg, ptr_next;
	logic [table_read_pkg::PTR_W-1:0] pend_reg, pend_next;
	logic sel_reg, sel_next;
	logic [table_read_pkg::BYTE_W-1:0] latch_reg, latch_next;
	logic stall_reg, stall_next;
	logic valid_reg, valid_next;
	logic [table_read_pkg::PTR_W-1:0] eff_ptr;
	logic rd_en;
	logic [table_read_pkg::WORD_W-1:0] rd_word;

	function automatic logic [table_read_pkg::BYTE_W-1:0] pick_byte(
		input logic [table_read_pkg::WORD_W-1:0] word,
		input logic hi
	);
		pick_byte = hi ? word[table_read_pkg::HIGH_BYTE_LSB +: table_read_pkg::BYTE_W]
			: word[0 +: table_read_pkg::BYTE_W];
	endfunction : pick_byte

	// Pre-increment addresses the byte after the current pointer
	always_comb begin
		eff_ptr = ptr_reg;
		if (cmd_i.mode == table_read_pkg::MODE_PRE_INC) begin
			eff_ptr = ptr_reg + table_read_pkg::PTR_STEP;
		end
	end

	// Fetch only on a taken request so the word holds still while the latch loads
	assign rd_en = (state_reg == table_read_pkg::ST_IDLE) && cmd_i.valid;

	prog_word_mem u_mem (
		.clk_sys_i(clk_sys_i),
		.rd_en_i(rd_en),
		.rd_addr_i(eff_ptr[table_read_pkg::PTR_W-1:1]),
		.rd_data_o(rd_word),
		.wr_i(prog_wr_i)
	);

	always_comb begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		pend_next = pend_reg;
		sel_next = sel_reg;
		latch_next = latch_reg;
		stall_next = stall_reg;
		valid_next = valid_reg;
		case (state_reg)
			table_read_pkg::ST_IDLE: begin
				if (cmd_i.valid) begin
					state_next = table_read_pkg::ST_READ;
					stall_next = 1'b1;
					valid_next = 1'b0;
					sel_next = eff_ptr[table_read_pkg::SEL_BIT];
					case (cmd_i.mode)
						table_read_pkg::MODE_POST_INC: pend_next = ptr_reg + table_read_pkg::PTR_STEP;
						table_read_pkg::MODE_POST_DEC: pend_next = ptr_reg - table_read_pkg::PTR_STEP;
						table_read_pkg::MODE_PRE_INC: pend_next = eff_ptr;
						default: pend_next = ptr_reg;
					endcase
				end else if (ptr_load_i) begin
					// A request wins a shared cycle; loads during a read are dropped
					ptr_next = ptr_data_i;
				end
			end
			table_read_pkg::ST_READ: begin
				latch_next = pick_byte(rd_word, sel_reg);
				ptr_next = pend_reg;
				stall_next = 1'b0;
				valid_next = 1'b1;
				state_next = table_read_pkg::ST_IDLE;
			end
			default: begin
				state_next = table_read_pkg::ST_IDLE;
				stall_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= table_read_pkg::ST_IDLE;
			ptr_reg <= table_read_pkg::PTR_RESET;
			pend_reg <= table_read_pkg::PTR_RESET;
			sel_reg <= 1'b0;
			latch_reg <= table_read_pkg::LATCH_RESET;
			stall_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ptr_reg <= ptr_next;
			pend_reg <= pend_next;
			sel_reg <= sel_next;
			latch_reg <= latch_next;
			stall_reg <= stall_next;
			valid_reg <= valid_next;
		end
	end

	assign table_byte_pointer_o = ptr_reg;
	assign table_read_latch_o = latch_reg;
	assign stall_o = stall_reg;
	assign latch_valid_o = valid_reg;

	// Each read spans two edges: request taken, then result loaded
	sequence s_issue;
		(state_reg == table_read_pkg::ST_IDLE) && cmd_i.valid;
	endsequence

	sequence s_post_inc;
		s_issue and (cmd_i.mode == table_read_pkg::MODE_POST_INC);
	endsequence

	sequence s_post_dec;
		s_issue and (cmd_i.mode == table_read_pkg::MODE_POST_DEC);
	endsequence

	sequence s_pre_inc;
		s_issue and (cmd_i.mode == table_read_pkg::MODE_PRE_INC);
	endsequence

	a_stall_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_issue |=> stall_o ##1 !stall_o)
		else $error("stall not exactly one cycle");

	a_latch_valid_next: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_issue |-> ##2 latch_valid_o)
		else $error("latch not valid after read");

	a_post_inc_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_post_inc |-> ##2 (table_byte_pointer_o == $past(ptr_reg, 2) + table_read_pkg::PTR_STEP))
		else $error("post increment did not advance by one byte");

	a_hold_pointer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_issue and (cmd_i.mode == table_read_pkg::MODE_HOLD) |-> ##2 $stable(table_byte_pointer_o))
		else $error("pointer moved in hold mode");

	a_low_byte_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_reg == table_read_pkg::ST_READ) && !sel_reg |=> (table_read_latch_o == $past(rd_word[7:0])))
		else $error("low byte not selected");

	a_high_byte_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_reg == table_read_pkg::ST_READ) && sel_reg |=> (table_read_latch_o == $past(rd_word[15:8])))
		else $error("high byte not selected");

	a_sel_from_lsb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_issue and (cmd_i.mode != table_read_pkg::MODE_PRE_INC) |=> (sel_reg == $past(ptr_reg[0])))
		else $error("byte select not from pointer bit zero");

	a_latch_stable_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_reg == table_read_pkg::ST_IDLE) |=> $stable(table_read_latch_o))
		else $error("latch changed without a read");

	a_latch_only_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(table_read_latch_o) |-> $past(state_reg) == table_read_pkg::ST_READ)
		else $error("latch loaded outside a read");

	a_post_dec_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_post_dec |-> ##2 (table_byte_pointer_o == $past(ptr_reg, 2) - table_read_pkg::PTR_STEP))
		else $error("post decrement did not step back by one byte");

	a_pre_inc_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_pre_inc |-> ##2 (table_byte_pointer_o == $past(ptr_reg, 2) + table_read_pkg::PTR_STEP))
		else $error("pre increment did not leave pointer one byte on");

	a_pre_inc_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_pre_inc |=> (sel_reg == !$past(ptr_reg[table_read_pkg::SEL_BIT])))
		else $error("pre increment byte select wrong");

	a_valid_low_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		stall_o |-> !latch_valid_o)
		else $error("latch valid high during a read");

	a_no_req_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_reg == table_read_pkg::ST_IDLE) && !cmd_i.valid |=> !stall_o)
		else $error("stall raised without a request");

	a_resume_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(stall_o) |-> (state_reg == table_read_pkg::ST_IDLE))
		else $error("core released before read finished");

	a_load_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_reg == table_read_pkg::ST_IDLE) && ptr_load_i && !cmd_i.valid
		|=> (table_byte_pointer_o == $past(ptr_data_i)))
		else $error("pointer load not taken");

	a_one_byte_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(table_read_latch_o) |-> $fell(stall_o))
		else $error("latch changed outside read completion");

	a_valid_rise_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(latch_valid_o) |-> $fell(stall_o))
		else $error("latch valid rose outside read completion");

	a_stall_drop_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(stall_o) |-> latch_valid_o)
		else $error("latch not valid when core resumes");

	a_latch_stable_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		stall_o |-> $stable(table_read_latch_o))
		else $error("latch moved while the word was fetched");

	a_pointer_stable_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		stall_o |-> $stable(table_byte_pointer_o))
		else $error("pointer moved before read completion");
endmodule : table_read_unit

// file: tb_top.sv
// Testbench for the table-read unit with a core model on the command port.
// Assumes memory is filled through the fill port before reading.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 0;
	logic rst_n_i = 0;
	logic ptr_load_i = 0;
	logic [16:0] ptr_data_i = '0;
	table_read_pkg::prog_write_s prog_wr_i = '0;
	table_read_pkg::table_cmd_s cmd;
	logic [16:0] ptr;
	logic [7:0] latch;
	logic stall;
	logic lvalid;
	int n_errors = 0;
	int checks_done = 0;
	initial forever #20 clk_sys_i = ~clk_sys_i;
	table_read_unit u_table_read_unit (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
		.ptr_load_i(ptr_load_i), .ptr_data_i(ptr_data_i), .prog_wr_i(prog_wr_i),
		.table_byte_pointer_o(ptr), .table_read_latch_o(latch), .stall_o(stall), .latch_valid_o(lvalid));
	core_model u_core_model (.clk_sys_i(clk_sys_i), .stall_i(stall), .cmd_o(cmd));
	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic fill(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		#1 prog_wr_i = {1'b1, a, d};
		@(posedge clk_sys_i);
		#1 prog_wr_i = '0;
	endtask : fill
	task automatic load(input logic [16:0] p);
		@(posedge clk_sys_i);
		#1 ptr_load_i = 1'b1;
		ptr_data_i = p;
		@(posedge clk_sys_i);
		#1 ptr_load_i = 1'b0;
	endtask : load
	task automatic rd(input table_read_pkg::ptr_mode_e m, input logic [7:0] eb, input logic [16:0] ep);
		int n;
		u_core_model.issue(m, n);
		chk("stall cycles", 17'(1), 17'(n));
		chk("latch", 17'(eb), 17'(latch));
		chk("pointer", ep, ptr);
		chk("latch valid", 17'h00001, 17'(lvalid));
	endtask : rd
	task automatic t_reset();
		chk("reset pointer", 17'h00000, ptr);
		chk("reset latch", 17'h00000, 17'(latch));
		chk("reset stall", 17'h00000, 17'(stall));
		chk("reset valid", 17'h00000, 17'(lvalid));
	endtask : t_reset
	task automatic t_mid_reset();
		@(posedge clk_sys_i);
		#1 rst_n_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		chk("mid reset pointer", 17'h00000, ptr);
		chk("mid reset latch", 17'h00000, 17'(latch));
		chk("mid reset valid", 17'h00000, 17'(lvalid));
		load(17'h00020);
		rd(table_read_pkg::MODE_POST_INC, 8'h5A, 17'h00021);
	endtask : t_mid_reset
	task automatic t_post_inc();
		fill(16'h0010, 16'hA55A);
		load(17'h00020);
		rd(table_read_pkg::MODE_POST_INC, 8'h5A, 17'h00021);
		rd(table_read_pkg::MODE_POST_INC, 8'hA5, 17'h00022);
	endtask : t_post_inc
	task automatic t_modes();
		fill(16'h0011, 16'hC33C);
		rd(table_read_pkg::MODE_HOLD, 8'h3C, 17'h00022);
		rd(table_read_pkg::MODE_PRE_INC, 8'hC3, 17'h00023);
		rd(table_read_pkg::MODE_POST_DEC, 8'hC3, 17'h00022);
		rd(table_read_pkg::MODE_HOLD, 8'h3C, 17'h00022);
	endtask : t_modes
	initial begin
		repeat (16) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		t_reset();
		t_post_inc();
		t_modes();
		t_mid_reset();
		tally_and_finish();
	end
	initial begin
		#80000;
		n_errors++;
		tally_and_finish();
	end
endmodule : tb_top
